// ---- pkg/boot_loader_regs.svh ----
/*
 Offsets, record layout and timing counts for the boot sequencer.
 Assumes byte-addressed info pages read one 32-bit word at a time.
*/
`ifndef BOOT_LOADER_REGS_SVH
`define BOOT_LOADER_REGS_SVH

// Vendor info page flags
`define VND_PROG_FLAG_OFS   16'h7F00
`define VND_AUTH_FLAG_OFS   16'h7F08
// Vendor key record
`define VND_KEY_LEN_OFS     16'h7D80 // RULE16
`define VND_KEY_CRC_OFS     16'h7D84
`define VND_KEY_DATA_OFS    16'h7D88
// Vendor lock-bit record
`define VND_LOCK_LEN_OFS    16'h7D00
// Vendor trim record
`define VND_TRIM_LEN_OFS    16'h7C80
// Product information record
`define VND_PROD_LEN_OFS    16'h7C40 // RULE20
`define VND_PROD_CRC_OFS    16'h7C44
`define VND_PROD_VER_OFS    16'h7C48
`define VND_PROD_DATA_OFS   16'h7C4C
// Calibration record
`define VND_ADC_LEN_OFS     16'h7B80 // RULE19
`define VND_ADC_CRC_OFS     16'h7B84
`define VND_ADC_DATA_OFS    16'h7B88
// User info page
`define USR_RDLOCK_OFS      16'h5F00 // RULE17
`define USR_AUTH_FLAG_OFS   16'h5F08
`define USR_KEY_LEN_OFS     16'h5D80 // RULE18
`define USR_KEY_CRC_OFS     16'h5D84
`define USR_KEY_DATA_OFS    16'h5D88
`define USR_LOCK_LEN_OFS    16'h5D00
`define USR_TRIM_LEN_OFS    16'h5C80

// Record layout: length word, CRC word, then data
`define REC_CRC_STEP        16'h0004
`define REC_DATA_STEP       16'h0008
`define REC_WORD_STEP       16'h0004
`define REC_MAX_WORDS       8'h10

// Main area layout
`define MAIN_PAGES          7'h40
`define MAIN_ENTRY_PAGE     6'h00
`define MAIN_CODE_FIRST     6'h01
`define MAIN_CODE_LAST      6'h3F
`define BLANK_WORD          32'hFFFFFFFF

// CRC-32 polynomial, initial value
`define CRC_POLY            32'h04C11DB7
`define CRC_INIT            32'hFFFFFFFF

// Edge spacing, half periods at 50 and 25 kHz, in clock cycles
`define CFG_HALF_MIN_CYC    16'h03E8
`define CFG_HALF_MAX_CYC    16'h07D0
`define CFG_EDGES_NEEDED    4'h8
`define CFG_WATCH_CYC       18'h30D40

`endif

// ---- pkg/boot_loader_pkg.sv ----
/*
 Types for the boot sequencer: the sequencer state and record phase enums.
 Assumes boot_loader_regs.svh carries all numbers.
*/
package boot_loader_pkg;
   // Gray-coded along the application path
   typedef enum logic [4:0] {
      st_cpu_init   = 5'h00,
      st_nvm_pwr    = 5'h01,
      st_blank_chk  = 5'h03,
      st_vtrim      = 5'h02,
      st_cfg_watch  = 5'h06,
      st_vlock      = 5'h07,
      st_utrim      = 5'h05,
      st_ulock      = 5'h04,
      st_entry_chk  = 5'h0C,
      st_run_nvm    = 5'h0D,
      st_cfg_init   = 5'h0F,
      st_cfg_mode   = 5'h0E,
      st_halt       = 5'h0A
   } boot_state_e;

   // Record fetch sub-phases
   typedef enum logic [1:0] {
      rec_len  = 2'h0,
      rec_crc  = 2'h1,
      rec_data = 2'h3,
      rec_done = 2'h2
   } rec_phase_e;
endpackage : boot_loader_pkg

// ---- core/secure_boot_loader.sv ----
/*
 Secure boot sequencer: steps the first (read-only) boot stage, checks
 each trim and lock record by CRC, applies trim and lock bits, and hands off
 to the nonvolatile entry point or stays in configuration mode.
 Assumes a word-wide info/main memory read port answering in one or more
 cycles with a valid pulse, and CPU/memory/power-up done strobes.
*/
// Behaviour
// (RULE1) Boot in two stages, nonvolatile split two
// (RULE2) Configuration mode runs read-only stage only
// (RULE3) Debug port held off during read-only stage
// (RULE4) Init CPU, memories, power nonvolatile, check blank
// (RULE5) Load vendor trim; bad CRC keeps defaults
// (RULE6) Sample request pin only after power-on
// (RULE7) Configuration path inits pins, SPI, transport
// (RULE8) Bad vendor lock record halts boot
// (RULE9) Bad user trim skipped, boot continues
// (RULE10) Bad user lock record halts boot
// (RULE11) Check entry point, then jump to it
// (RULE12) Trim and locks applied on every boot; a configuration-mode boot applies vendor trim only
// (RULE13) Main area 64 pages, page 0 entry
// (RULE14) Vector table relocated to main area
// (RULE15) Vendor flags at 0x7F08 and 0x7F00
// (RULE16) Vendor key record length, CRC, keys
// (RULE17) User flags at 0x5F08 and 0x5F00
// (RULE18) User key record length, CRC, key
// (RULE19) Calibration record length, CRC, 60 bytes
// (RULE20) Product record length, CRC, version, data
// (RULE21) Request detected from edges, 25-50 kHz
// (RULE22) Configuration mode reached only over SPI
// (RULE23) Vendor info page read only
// (RULE24) CRC over length bytes versus stored CRC
// (RULE25) Halt persists until next reset
`timescale 1ns/1ps
`include "boot_loader_regs.svh"

module secure_boot_loader (
   input  wire logic                       clk_sys_in,
   input  wire logic                       reset_in,
   input  wire logic                       por_boot_in,      // Boot follows power-on
   input  wire logic                       cpu_init_done_in, // CPU/memory ready
   input  wire logic                       nvm_pwr_done_in,  // Power-up complete
   input  wire logic                       config_request_pin_in,
   input  wire logic                       mem_valid_in,     // Read word valid
   input  wire logic [31:0]                mem_rdata_in,
   output logic                            mem_req_out,      // Read request
   output logic [15:0]                     mem_addr_out,     // Info byte addr
   output logic                            mem_main_sel_out, // Main area select
   output logic                            mem_write_en_out, // Never set
   output logic                            cpu_init_out,
   output logic                            nvm_pwr_up_out,
   output logic                            jtag_enable_out,
   output logic                            nvm_blank_out,
   output logic [31:0]                     vnd_trim_out,
   output logic                            vnd_trim_apply_out,
   output logic [31:0]                     usr_trim_out,
   output logic                            usr_trim_apply_out,
   output logic [31:0]                     vnd_lock_out,
   output logic [31:0]                     usr_lock_out,
   output logic                            lock_apply_out,
   output logic                            cfg_periph_init_out, // Pins/SPI/TL
   output logic                            spi_only_out,
   output logic                            configuration_mode_out,
   output logic                            vector_remap_out,
   output logic                            nvm_jump_out,     // One-cycle jump
   output logic [5:0]                      entry_page_out,
   output logic                            halt_out,
   output logic [4:0]                      boot_state_out
);
   import boot_loader_pkg::*;

   // One-step CRC-32 over a byte, MSB first
   function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                            input logic [7:0]  d);
      logic [31:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         r = (r[31] ^ d[i]) ? ((r << 1) ^ `CRC_POLY) : (r << 1);
      end
      return r;
   endfunction : crc_byte

   // Record base for a state, used by the record fetch on each state change
   function automatic logic [15:0] rec_base(input boot_state_e s);
      case (s)
         st_vtrim: rec_base = `VND_TRIM_LEN_OFS;
         st_vlock: rec_base = `VND_LOCK_LEN_OFS;
         st_utrim: rec_base = `USR_TRIM_LEN_OFS;
         st_ulock: rec_base = `USR_LOCK_LEN_OFS;
         default:  rec_base = 16'(`MAIN_ENTRY_PAGE);
      endcase
   endfunction : rec_base

   boot_state_e       state_r, state_nxt;     // Sequencer state
   rec_phase_e        phase_r;                // Record fetch phase
   logic              req_r;                  // Outstanding read
   logic [15:0]       addr_r;                 // Read address
   logic [31:0]       len_r;                  // Record length bytes
   logic [31:0]       crc_exp_r;              // Stored CRC
   logic [31:0]       crc_r;                  // Running CRC
   logic [31:0]       first_word_r;           // First data word
   logic [7:0]        words_r;                // Data words read
   logic              rec_ok_r;               // Last record result
   logic              pin_s1_r, pin_s2_r;     // Pin synchroniser
   logic              pin_d_r;                // Previous synced level
   logic [15:0]       gap_r;                  // Cycles since last edge
   logic [3:0]        edges_r;                // Good edges in a row
   logic [17:0]       watch_r;                // Watch window count
   logic              cfg_req_r;              // Request detected
   logic              blank_r;                // Main area blank

   // Data words the length calls for, and whether this is the last data word
   wire  [31:0] words_need = (len_r + 32'h3) >> 2;
   wire         data_last  = ({24'h0, words_r} + 32'h1 >= words_need) ||
                             (words_r + 8'h1 >= `REC_MAX_WORDS);
   wire  [31:0] crc_word   = crc_byte(crc_byte(crc_byte(crc_byte(crc_r,
                                mem_rdata_in[31:24]), mem_rdata_in[23:16]),
                                mem_rdata_in[15:8]), mem_rdata_in[7:0]);
   wire         rec_state  = (state_r == st_vtrim) || (state_r == st_vlock) ||
                             (state_r == st_utrim) || (state_r == st_ulock);
   wire         rec_end    = rec_state && (phase_r == rec_done);
   wire         pin_edge   = pin_s2_r ^ pin_d_r;
   wire         gap_good   = (gap_r >= `CFG_HALF_MIN_CYC) &&
                             (gap_r <= `CFG_HALF_MAX_CYC);
   wire         watch_end  = (watch_r == `CFG_WATCH_CYC) || !por_boot_in;
   wire         entry_ok   = mem_valid_in && (mem_rdata_in != `BLANK_WORD);

   // Next-state decode
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         st_cpu_init:  if (cpu_init_done_in) state_nxt = st_nvm_pwr; // RULE4
         st_nvm_pwr:   if (nvm_pwr_done_in) state_nxt = st_blank_chk;
         st_blank_chk: if (mem_valid_in) state_nxt = st_vtrim;
         st_vtrim:     if (rec_end) state_nxt = st_cfg_watch; // RULE5
         st_cfg_watch: begin
            if (cfg_req_r) state_nxt = st_cfg_init; // RULE2
            else if (watch_end) state_nxt = st_vlock;
         end
         st_vlock: if (rec_end)
            state_nxt = rec_ok_r ? st_utrim : st_halt; // RULE8
         st_utrim: if (rec_end) state_nxt = st_ulock; // RULE9
         st_ulock: if (rec_end)
            state_nxt = rec_ok_r ? st_entry_chk : st_halt; // RULE10
         st_entry_chk: if (mem_valid_in)
            state_nxt = entry_ok ? st_run_nvm : st_halt; // RULE11
         st_run_nvm:   state_nxt = st_run_nvm;
         st_cfg_init:  state_nxt = st_cfg_mode; // RULE7
         st_cfg_mode:  state_nxt = st_cfg_mode;
         st_halt:      state_nxt = st_halt; // RULE25
         default:      state_nxt = st_cpu_init;
      endcase
   end

   // Sequencer register; every reset re-runs from the top
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) state_r <= st_cpu_init; // RULE12
      else          state_r <= state_nxt;
   end

   // Record fetch: length, CRC, then data words with running CRC
   always_ff @(posedge clk_sys_in) begin
      if (reset_in || state_r != state_nxt) begin
         phase_r      <= rec_len;
         req_r        <= 1'b0;
         addr_r       <= rec_base(state_nxt);
         crc_r        <= `CRC_INIT;
         words_r      <= 8'h00;
         len_r        <= 32'h0;
         crc_exp_r    <= 32'h0;
         first_word_r <= 32'h0;
      end else if (rec_state && phase_r != rec_done) begin
         req_r <= !mem_valid_in;
         if (mem_valid_in) begin
            case (phase_r)
               rec_len: begin
                  len_r   <= mem_rdata_in;
                  phase_r <= rec_crc;
                  addr_r  <= addr_r + `REC_CRC_STEP;
               end
               rec_crc: begin
                  crc_exp_r <= mem_rdata_in;
                  addr_r    <= addr_r + `REC_WORD_STEP;
                  phase_r   <= (len_r == 32'h0) ? rec_done : rec_data;
               end
               rec_data: begin
                  crc_r   <= crc_word; // RULE24
                  if (words_r == 8'h00) first_word_r <= mem_rdata_in;
                  words_r <= words_r + 8'h1;
                  addr_r  <= addr_r + `REC_WORD_STEP;
                  if (data_last) phase_r <= rec_done;
               end
               default: phase_r <= rec_done;
            endcase
         end
      end else begin
         req_r <= (state_r == st_blank_chk || state_r == st_entry_chk)
                  && !mem_valid_in;
      end
   end

   // Integrity verdict once the record is read
   always_ff @(posedge clk_sys_in) begin
      if (reset_in)
         rec_ok_r <= 1'b0;
      else if (phase_r != rec_done)
         rec_ok_r <= (phase_r == rec_data) && mem_valid_in && data_last &&
                     (crc_word == crc_exp_r); // RULE24
   end

   // Request pin: two flops before anything reads it
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         pin_d_r  <= 1'b0;
      end else begin
         pin_s1_r <= config_request_pin_in;
         pin_s2_r <= pin_s1_r;
         pin_d_r  <= pin_s2_r;
      end
   end

   // Edge-rate detector, only while watching after power-on
   always_ff @(posedge clk_sys_in) begin
      if (reset_in || state_r != st_cfg_watch) begin
         gap_r     <= 16'h0;
         edges_r   <= 4'h0;
         watch_r   <= 18'h0;
         cfg_req_r <= 1'b0;
      end else if (por_boot_in) begin // RULE6
         watch_r <= watch_r + 18'h1;
         if (pin_edge) begin
            gap_r   <= 16'h0;
            edges_r <= gap_good ? edges_r + 4'h1 : 4'h0; // RULE21
            if (gap_good && edges_r + 4'h1 == `CFG_EDGES_NEEDED)
               cfg_req_r <= 1'b1;
         end else if (gap_r != 16'hFFFF) begin
            gap_r <= gap_r + 16'h1;
         end
      end
   end

   // Applied trim and lock values; only a good record is applied
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         vnd_trim_out       <= 32'h0; // RULE5
         usr_trim_out       <= 32'h0;
         vnd_lock_out       <= 32'h0;
         usr_lock_out       <= 32'h0;
         vnd_trim_apply_out <= 1'b0;
         usr_trim_apply_out <= 1'b0;
         lock_apply_out     <= 1'b0;
      end else begin
         vnd_trim_apply_out <= 1'b0;
         usr_trim_apply_out <= 1'b0;
         lock_apply_out     <= 1'b0;
         if (rec_end && state_nxt != state_r && rec_ok_r) begin
            case (state_r)
               st_vtrim: begin
                  vnd_trim_out       <= first_word_r; // RULE12
                  vnd_trim_apply_out <= 1'b1;
               end
               st_utrim: begin
                  usr_trim_out       <= first_word_r; // RULE9
                  usr_trim_apply_out <= 1'b1;
               end
               st_vlock: begin
                  vnd_lock_out   <= first_word_r; // RULE8
                  lock_apply_out <= 1'b1;
               end
               st_ulock: begin
                  usr_lock_out   <= first_word_r; // RULE10
                  lock_apply_out <= 1'b1;
               end
               default: lock_apply_out <= 1'b0;
            endcase
         end
      end
   end

   // Blank check of the entry page's first word
   always_ff @(posedge clk_sys_in) begin
      if (reset_in)
         blank_r <= 1'b0;
      else if (state_r == st_blank_chk && mem_valid_in)
         blank_r <= (mem_rdata_in == `BLANK_WORD); // RULE4
   end

   // Memory port and status outputs, all registered
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         mem_req_out            <= 1'b0;
         mem_addr_out           <= 16'h0;
         mem_main_sel_out       <= 1'b0;
         mem_write_en_out       <= 1'b0;
         cpu_init_out           <= 1'b0;
         nvm_pwr_up_out         <= 1'b0;
         jtag_enable_out        <= 1'b0;
         nvm_blank_out          <= 1'b0;
         cfg_periph_init_out    <= 1'b0;
         spi_only_out           <= 1'b0;
         configuration_mode_out <= 1'b0;
         vector_remap_out       <= 1'b0;
         nvm_jump_out           <= 1'b0;
         entry_page_out         <= `MAIN_ENTRY_PAGE;
         halt_out               <= 1'b0;
         boot_state_out         <= 5'h0;
      end else begin
         mem_req_out      <= req_r && !mem_valid_in;
         mem_addr_out     <= addr_r; // RULE15
         // Entry and blank checks read page 0 of the main area
         mem_main_sel_out <= (state_r == st_blank_chk) ||
                             (state_r == st_entry_chk); // RULE13
         mem_write_en_out <= 1'b0; // RULE23
         cpu_init_out     <= (state_r == st_cpu_init); // RULE4
         nvm_pwr_up_out   <= (state_r == st_nvm_pwr);
         // Debug stays off until the nonvolatile stage owns the core
         jtag_enable_out  <= (state_r == st_run_nvm); // RULE3
         nvm_blank_out    <= blank_r;
         cfg_periph_init_out <= (state_r == st_cfg_init); // RULE7
         spi_only_out     <= (state_r == st_cfg_init) ||
                             (state_r == st_cfg_mode); // RULE22
         configuration_mode_out <= (state_r == st_cfg_mode); // RULE2
         vector_remap_out <= (state_r == st_run_nvm); // RULE14
         nvm_jump_out     <= (state_r == st_entry_chk) &&
                             (state_nxt == st_run_nvm); // RULE1
         entry_page_out   <= `MAIN_ENTRY_PAGE; // RULE11
         halt_out         <= (state_r == st_halt); // RULE25
         boot_state_out   <= state_r;
      end
   end
endmodule : secure_boot_loader

// ---- sim/boot_loader_props.sv ----
/*
 Port checker for the boot sequencer.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module boot_loader_props
   import boot_loader_pkg::*;
(
   input wire logic        clk_sys_in,
   input wire logic        reset_in,
   input wire logic        por_boot_in,
   input wire logic        mem_valid_in,
   input wire logic        mem_req_out,
   input wire logic [15:0] mem_addr_out,
   input wire logic        mem_main_sel_out,
   input wire logic        mem_write_en_out,
   input wire logic        jtag_enable_out,
   input wire logic        cfg_periph_init_out,
   input wire logic        spi_only_out,
   input wire logic        configuration_mode_out,
   input wire logic        vector_remap_out,
   input wire logic        nvm_jump_out,
   input wire logic [5:0]  entry_page_out,
   input wire logic        halt_out,
   input wire logic [4:0]  boot_state_out
);
   // Single domain, reset masks everything
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);

   property p_jtag_off;
      jtag_enable_out |-> boot_state_out == st_run_nvm;
   endproperty
   a_jtag_off: assert property (p_jtag_off)
      else $error("debug open early");
   property p_no_write;
      !mem_write_en_out;
   endproperty
   a_no_write: assert property (p_no_write)
      else $error("write strobe raised");
   property p_halt_hold;
      halt_out |=> halt_out && !nvm_jump_out && !jtag_enable_out;
   endproperty
   a_halt_hold: assert property (p_halt_hold)
      else $error("halt left");
   property p_cfg_hold;
      configuration_mode_out |=> configuration_mode_out && !nvm_jump_out
         && !mem_main_sel_out;
   endproperty
   a_cfg_hold: assert property (p_cfg_hold)
      else $error("config mode left");
   property p_cfg_spi;
      configuration_mode_out |-> spi_only_out;
   endproperty
   a_cfg_spi: assert property (p_cfg_spi)
      else $error("config mode not spi only");
   property p_cfg_init;
      cfg_periph_init_out |=> !cfg_periph_init_out ##[0:3]
         configuration_mode_out;
   endproperty
   a_cfg_init: assert property (p_cfg_init)
      else $error("init without mode");
   property p_cfg_por;
      $rose(configuration_mode_out) |-> por_boot_in;
   endproperty
   a_cfg_por: assert property (p_cfg_por)
      else $error("config mode on warm boot");
   property p_jump;
      nvm_jump_out |=> !nvm_jump_out ##[0:2] (jtag_enable_out
         && vector_remap_out && entry_page_out == 6'h00);
   endproperty
   a_jump: assert property (p_jump)
      else $error("handoff wrong");
   property p_req_hold;
      mem_req_out && !mem_valid_in |=> mem_req_out
         && $stable(mem_addr_out) && $stable(mem_main_sel_out);
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("request not held");
   property p_req_page;
      mem_req_out && !mem_main_sel_out |-> mem_addr_out[15:14] == 2'b01;
   endproperty
   a_req_page: assert property (p_req_page)
      else $error("read off info pages");
endmodule : boot_loader_props

// ---- sim/info_mem_model.sv ----
/*
 Behavioural info/main memory answering word reads.
 Assumes the bench loads records before releasing reset.
*/
`timescale 1ns/1ps
module info_mem_model (
   input  wire logic        clk_sys_in,
   input  wire logic        mem_req_in,
   input  wire logic [15:0] mem_addr_in,
   input  wire logic        mem_main_sel_in,
   input  wire logic [3:0]  lat_in,
   output logic             mem_valid_out,
   output logic [31:0]      mem_rdata_out
);
   logic [31:0] info_r [logic [15:0]]; // Sparse info pages
   logic [31:0] entry_r;               // Main page 0 entry word
   int          wait_r = 0;            // Latency counter
   initial mem_valid_out = 1'b0;
   initial mem_rdata_out = 32'h00000000;
   // Bench-side record load; device side can never write
   task automatic load(input logic [15:0] a, input logic [31:0] d);
      info_r[a] = d;
   endtask : load
   // Answer after lat_in cycles; idle bus shows a toggling pattern
   always @(posedge clk_sys_in) begin
      if (mem_valid_out) begin
         mem_valid_out <= 1'b0;
         mem_rdata_out <= ~mem_rdata_out;
      end else if (mem_req_in && wait_r >= int'(lat_in)) begin
         mem_valid_out <= 1'b1;
         wait_r        <= 0;
         // Unwritten cells read as erased
         mem_rdata_out <= mem_main_sel_in ? entry_r :
            info_r.exists(mem_addr_in) ? info_r[mem_addr_in] : 32'hFFFFFFFF;
      end else begin
         wait_r        <= mem_req_in ? wait_r + 1 : 0;
         mem_rdata_out <= ~mem_rdata_out;
      end
   end
endmodule : info_mem_model

// ---- sim/tb_top.sv ----
/*
 Bench for the boot sequencer: one boot per scenario code.
 Assumes the memory model and checker compiled beforehand.
*/
`timescale 1ns/1ps
`include "boot_loader_regs.svh"
module tb_top;
   logic        clk_sys_in = 1'b0, reset_in = 1'b1, por_boot_in = 1'b0;
   logic        cpu_init_done_in = 1'b0, nvm_pwr_done_in = 1'b0;
   logic        config_request_pin_in = 1'b0, tog_en = 1'b0;
   logic        mem_valid_in, mem_req_out, mem_main_sel_out;
   logic        mem_write_en_out, cpu_init_out, nvm_pwr_up_out;
   logic        jtag_enable_out, nvm_blank_out, vnd_trim_apply_out;
   logic        usr_trim_apply_out, lock_apply_out, cfg_periph_init_out;
   logic        spi_only_out, configuration_mode_out, vector_remap_out;
   logic        nvm_jump_out, halt_out, jumped;
   logic [31:0] mem_rdata_in, vnd_trim_out, usr_trim_out;
   logic [31:0] vnd_lock_out, usr_lock_out;
   logic [15:0] mem_addr_out;
   logic [5:0]  entry_page_out;
   logic [4:0]  boot_state_out;
   logic [3:0]  lat = 4'h0;       // Memory answer delay
   int          n_mismatch = 0, checks = 0, cyc = 0, gap = 0;
   // Scenario bits: 0 vtrim ok, 1 vlock ok, 2 utrim ok, 3 ulock ok,
   // 4 blank entry, 5 pin toggling, 6 power-on boot
   int          scen[$] = '{'h0F, 'h0F, 'h0E, 'h0B, 'h0D, 'h07, 'h1F,
                            'h2F, 'h6F, 'h6E};

   always #5 clk_sys_in = ~clk_sys_in;

   secure_boot_loader secure_boot_loader_inst (
      .clk_sys_in, .reset_in, .por_boot_in, .cpu_init_done_in,
      .nvm_pwr_done_in, .config_request_pin_in, .mem_valid_in,
      .mem_rdata_in, .mem_req_out, .mem_addr_out, .mem_main_sel_out,
      .mem_write_en_out, .cpu_init_out, .nvm_pwr_up_out, .jtag_enable_out,
      .nvm_blank_out, .vnd_trim_out, .vnd_trim_apply_out, .usr_trim_out,
      .usr_trim_apply_out, .vnd_lock_out, .usr_lock_out, .lock_apply_out,
      .cfg_periph_init_out, .spi_only_out, .configuration_mode_out,
      .vector_remap_out, .nvm_jump_out, .entry_page_out, .halt_out,
      .boot_state_out);
   info_mem_model info_mem_model_inst (
      .clk_sys_in, .mem_req_in(mem_req_out), .mem_addr_in(mem_addr_out),
      .mem_main_sel_in(mem_main_sel_out), .lat_in(lat),
      .mem_valid_out(mem_valid_in), .mem_rdata_out(mem_rdata_in));

   // Request pin toggler, edges 1101..1901 cycles apart (25-50 kHz)
   always @(posedge clk_sys_in) begin
      if (!tog_en) gap <= 0;
      else if (gap == 0) begin
         config_request_pin_in <= ~config_request_pin_in;
         gap                   <= $urandom_range(1100, 1900);
      end else gap <= gap - 1;
   end
   // Hang guard; ten boots need well under 60k cycles
   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_mismatch++;
         results();
      end
   end

   // Reference CRC: MSB first, no final inversion
   function automatic logic [31:0] crc_of(input logic [31:0] d);
      logic [31:0] c;
      c = `CRC_INIT;
      for (int i = 31; i >= 0; i--)
         c = (c << 1) ^ ((c[31] ^ d[i]) ? `CRC_POLY : 32'h00000000);
      return c;
   endfunction : crc_of
   // One-word record; a bad one carries a flipped CRC
   task automatic put_rec(input logic [15:0] b, input logic [31:0] d,
                          input bit ok);
      info_mem_model_inst.load(b, 32'h00000004);
      info_mem_model_inst.load(b + `REC_CRC_STEP, ok ? crc_of(d) : ~crc_of(d));
      info_mem_model_inst.load(b + `REC_DATA_STEP, d);
   endtask : put_rec
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // One boot: load records, reset, run to handoff/halt/mode, compare
   task automatic boot(input int s);
      logic [31:0] vt, vl, ut, ul;
      bit          cfg, jmp;
      {vt, vl, ut, ul} = {$urandom(), $urandom(), $urandom(), $urandom()};
      cfg = s[5] && s[6];
      jmp = !cfg && !s[4] && s[1] && s[3];
      put_rec(`VND_TRIM_LEN_OFS, vt, s[0]);
      put_rec(`VND_LOCK_LEN_OFS, vl, s[1]);
      put_rec(`USR_TRIM_LEN_OFS, ut, s[2]);
      put_rec(`USR_LOCK_LEN_OFS, ul, s[3]);
      info_mem_model_inst.entry_r = s[4] ? `BLANK_WORD : {1'b0, vt[30:0]};
      @(posedge clk_sys_in);
      reset_in         <= 1'b1;
      cpu_init_done_in <= 1'b0;
      nvm_pwr_done_in  <= 1'b0;
      por_boot_in      <= s[6];
      tog_en           <= s[5];
      lat              <= 4'($urandom_range(0, 6));
      repeat (10) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      @(posedge clk_sys_in);
      cpu_init_done_in <= 1'b1;
      nvm_pwr_done_in  <= 1'b1;
      jumped = 1'b0;
      for (int k = 0; k < 25000; k++) begin
         @(posedge clk_sys_in);
         #1;
         if (nvm_jump_out === 1'b1) jumped = 1'b1;
         if (jumped || halt_out === 1'b1 || configuration_mode_out === 1'b1)
            break;
      end
      tog_en <= 1'b0;
      // Long settle shows halt and mode persist
      repeat (20) @(posedge clk_sys_in);
      #1;
      chk("jump", 32'(jmp), 32'(jumped));
      chk("halt", 32'(!cfg && !jmp), 32'(halt_out));
      chk("config_mode", 32'(cfg), 32'(configuration_mode_out));
      chk("jtag", 32'(jmp), 32'(jtag_enable_out));
      chk("remap", 32'(jmp), 32'(vector_remap_out));
      chk("blank", 32'(s[4]), 32'(nvm_blank_out));
      if (!s[4]) begin
         chk("vnd_trim", s[0] ? vt : 32'h0, vnd_trim_out);
         chk("vnd_lock", (!cfg && s[1]) ? vl : 32'h0, vnd_lock_out);
         chk("usr_trim", (!cfg && s[1] && s[2]) ? ut : 32'h0,
             usr_trim_out);
         chk("usr_lock", (!cfg && s[1] && s[3]) ? ul : 32'h0,
             usr_lock_out);
      end
   endtask : boot

   task automatic results;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results

   // Main sequence; repeated good boot shows values reapplied
   initial begin
      void'($urandom(32'hFB9F7417));
      foreach (scen[i]) boot(scen[i]);
      results();
   end
endmodule : tb_top

bind secure_boot_loader boot_loader_props boot_loader_props_inst (
   .clk_sys_in, .reset_in, .por_boot_in, .mem_valid_in, .mem_req_out,
   .mem_addr_out, .mem_main_sel_out, .mem_write_en_out, .jtag_enable_out,
   .cfg_periph_init_out, .spi_only_out, .configuration_mode_out,
   .vector_remap_out, .nvm_jump_out, .entry_page_out, .halt_out,
   .boot_state_out);
